/* shared/smt_defines.svh */
// register indices, bit positions and reset values of the transmitter
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH

// register indices on the plain register port
`define SMT_IDX_TXSC 3'h0
`define SMT_IDX_RXSC 3'h1
`define SMT_IDX_TXBUF 3'h2
`define SMT_IDX_DIVISOR 3'h3
`define SMT_IDX_PFLAG 3'h4
`define SMT_IDX_PENABLE 3'h5

// transmit status and control bits
`define SMT_TXSC_MASTER 7
`define SMT_TXSC_NINE 6
`define SMT_TXSC_TRANSMIT_ENABLE_BIT 5
`define SMT_TXSC_SYNC 4
`define SMT_TXSC_EMPTY 1
`define SMT_TXSC_BIT9 0

// receive status and control bits
`define SMT_RXSC_PORT 7
`define SMT_RXSC_SINGLE 5
`define SMT_RXSC_CONT 4

// flag and enable bit of the transmitter
`define SMT_PFLAG_TX 4
`define SMT_PENABLE_TX 4

// reset values
`define SMT_RST_BYTE 8'h00
`define SMT_RST_CNT 16'h0000
`define SMT_RST_IDX 4'h0
`define SMT_RST_SHIFT 9'h000

// last bit index of an 8-bit and a 9-bit shift, and unit steps
`define SMT_LAST_BIT8 4'h7
`define SMT_LAST_BIT9 4'h8
`define SMT_ONE_IDX 4'h1
`define SMT_ONE_CNT 16'h0001

`endif

/* shared/smt_pkg.sv */
// types shared by the synchronous master transmitter
`default_nettype none

package smt_pkg;

    // one register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smt_bus_req_type;

    // pin drive of the clock and data lines
    typedef struct packed {
        logic shift_clock_line_out;
        logic shift_clock_line_oe;
        logic serial_data_line_out;
        logic serial_data_line_oe;
    } smt_pins_type;

    // state of the shift register
    typedef enum logic [1:0] {
        SMT_EMPTY = 2'b00,
        SMT_SHIFT = 2'b01,
        SMT_HELD = 2'b10
    } smt_state_type;

endpackage

`default_nettype wire

/* design/smt_transmitter.sv */
// synchronous master transmit path of a serial port, with its registers
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "smt_defines.svh"
`default_nettype none

module smt_transmitter #(
    parameter int HALF_SCALE = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire smt_pkg::smt_bus_req_type i_bus,
    input wire logic i_single_rx_done,
    output logic [7:0] o_rdata,
    output var smt_pkg::smt_pins_type o_pins,
    output logic o_tx_irq
);

    // refuse a divisor scale the 16-bit counter cannot carry
    initial
    begin
        if (HALF_SCALE < 1 || HALF_SCALE > 255)
        begin
            $error("HALF_SCALE must lie between 1 and 255");
        end
    end

    // register file state
    logic [7:0] transmit_status_control;
    logic [7:0] next_transmit_status_control;
    logic [7:0] receive_status_control;
    logic [7:0] next_receive_status_control;
    logic [7:0] transmit_buffer;
    logic [7:0] next_transmit_buffer;
    logic [7:0] baud_rate_divisor;
    logic [7:0] next_baud_rate_divisor;
    logic [7:0] peripheral_enable_register;
    logic [7:0] next_peripheral_enable_register;
    logic buffer_full;
    logic next_buffer_full;
    logic transmit_buffer_empty_flag;
    logic next_transmit_buffer_empty_flag;
    logic [7:0] next_rdata;
    logic next_tx_irq;

    // baud generator state
    logic [15:0] brg_count;
    logic [15:0] next_brg_count;
    logic brg_tick;

    // shifter state
    smt_pkg::smt_state_type state;
    smt_pkg::smt_state_type next_state;
    logic [8:0] transmit_shift_register;
    logic [8:0] next_transmit_shift_register;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [3:0] last_idx;
    logic [3:0] next_last_idx;
    logic clock_level;
    logic next_clock_level;
    logic data_level;
    logic next_data_level;
    smt_pkg::smt_pins_type next_pins;

    // decoded control bits
    logic sync_mode;
    logic port_pin_enable;
    logic clock_source_master_select;
    logic transmit_enable_bit;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic nine_bit_transmit_select;
    logic ninth_transmit_bit;
    logic transmit_interrupt_enable;
    logic shifter_empty_status;
    logic rx_active;
    logic load_shifter;
    logic buffer_write;

    // write decode, used by several processes
    function automatic logic is_write(input smt_pkg::smt_bus_req_type req,
                                      input logic [2:0] idx);
        is_write = req.wr && (req.addr == idx);
    endfunction

    // control bits taken from the registers
    assign sync_mode = transmit_status_control[`SMT_TXSC_SYNC];
    assign port_pin_enable = receive_status_control[`SMT_RXSC_PORT];
    assign clock_source_master_select = transmit_status_control[`SMT_TXSC_MASTER];
    assign transmit_enable_bit = transmit_status_control[`SMT_TXSC_TRANSMIT_ENABLE_BIT];
    assign continuous_receive_enable = receive_status_control[`SMT_RXSC_CONT];
    assign single_receive_enable = receive_status_control[`SMT_RXSC_SINGLE];
    assign nine_bit_transmit_select = transmit_status_control[`SMT_TXSC_NINE];
    assign ninth_transmit_bit = transmit_status_control[`SMT_TXSC_BIT9];
    assign transmit_interrupt_enable = peripheral_enable_register[`SMT_PENABLE_TX];
    assign rx_active = continuous_receive_enable || single_receive_enable;
    assign shifter_empty_status = (state == smt_pkg::SMT_EMPTY);
    assign buffer_write = is_write(i_bus, `SMT_IDX_TXBUF);

    // shifter takes the buffer only when empty and enabled
    assign load_shifter = buffer_full && transmit_enable_bit && shifter_empty_status;

    // register file next values and read data
    always_comb
    begin
        next_transmit_status_control = transmit_status_control;
        next_receive_status_control = receive_status_control;
        next_transmit_buffer = transmit_buffer;
        next_baud_rate_divisor = baud_rate_divisor;
        next_peripheral_enable_register = peripheral_enable_register;
        next_buffer_full = buffer_full;
        next_rdata = `SMT_RST_BYTE;
        // single receive finished: its enable clears itself
        if (i_single_rx_done)
        begin
            next_receive_status_control[`SMT_RXSC_SINGLE] = 1'b0;
        end
        if (is_write(i_bus, `SMT_IDX_TXSC))
        begin
            next_transmit_status_control = i_bus.wdata;
        end
        if (is_write(i_bus, `SMT_IDX_RXSC))
        begin
            next_receive_status_control = i_bus.wdata; // a write wins over auto-clear
        end
        if (is_write(i_bus, `SMT_IDX_DIVISOR))
        begin
            next_baud_rate_divisor = i_bus.wdata;
        end
        if (is_write(i_bus, `SMT_IDX_PENABLE))
        begin
            next_peripheral_enable_register = i_bus.wdata;
        end
        // the status bit is never stored, the shifter owns it
        next_transmit_status_control[`SMT_TXSC_EMPTY] = 1'b0;
        // buffer empties on the one-cycle move into the shifter
        if (load_shifter)
        begin
            next_buffer_full = 1'b0;
        end
        // a new word refills the buffer and clears the flag
        if (buffer_write)
        begin
            next_transmit_buffer = i_bus.wdata;
            next_buffer_full = 1'b1;
        end
        // flag mirrors an empty buffer; a flag register write has no effect
        next_transmit_buffer_empty_flag = !next_buffer_full;
        // interrupt gated by its enable, flag itself ungated
        next_tx_irq = next_transmit_buffer_empty_flag
                      && next_peripheral_enable_register[`SMT_PENABLE_TX];
        // read data; the shift register has no address
        if (i_bus.rd)
        begin
            unique case (i_bus.addr)
                `SMT_IDX_TXSC:
                begin
                    next_rdata = transmit_status_control;
                    next_rdata[`SMT_TXSC_EMPTY] = shifter_empty_status;
                end
                `SMT_IDX_RXSC: next_rdata = receive_status_control;
                `SMT_IDX_TXBUF: next_rdata = transmit_buffer;
                `SMT_IDX_DIVISOR: next_rdata = baud_rate_divisor;
                `SMT_IDX_PFLAG:
                begin
                    next_rdata[`SMT_PFLAG_TX] = transmit_buffer_empty_flag;
                end
                `SMT_IDX_PENABLE: next_rdata = peripheral_enable_register;
                default: next_rdata = `SMT_RST_BYTE;
            endcase
        end
    end

    // register file flip-flops
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            transmit_status_control <= `SMT_RST_BYTE;
            receive_status_control <= `SMT_RST_BYTE;
            transmit_buffer <= `SMT_RST_BYTE;
            baud_rate_divisor <= `SMT_RST_BYTE;
            peripheral_enable_register <= `SMT_RST_BYTE;
            buffer_full <= 1'b0;
            transmit_buffer_empty_flag <= 1'b1;
            o_rdata <= `SMT_RST_BYTE;
            o_tx_irq <= 1'b0;
        end
        else
        begin
            transmit_status_control <= next_transmit_status_control;
            receive_status_control <= next_receive_status_control;
            transmit_buffer <= next_transmit_buffer;
            baud_rate_divisor <= next_baud_rate_divisor;
            peripheral_enable_register <= next_peripheral_enable_register;
            buffer_full <= next_buffer_full;
            transmit_buffer_empty_flag <= next_transmit_buffer_empty_flag;
            o_rdata <= next_rdata;
            o_tx_irq <= next_tx_irq;
        end
    end

    // baud generator: half period of (divisor * scale + 1) cycles
    always_comb
    begin
        brg_tick = 1'b0;
        next_brg_count = brg_count;
        if (!(transmit_enable_bit || rx_active))
        begin
            next_brg_count = `SMT_RST_CNT; // held in reset
        end
        else if (brg_count == `SMT_RST_CNT)
        begin
            brg_tick = 1'b1; // first tick at once after enabling
            next_brg_count = 16'({8'h00, baud_rate_divisor} * HALF_SCALE);
        end
        else
        begin
            next_brg_count = brg_count - `SMT_ONE_CNT;
        end
    end

    // baud generator flip-flops
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            brg_count <= `SMT_RST_CNT;
        end
        else
        begin
            brg_count <= next_brg_count;
        end
    end

    // shifter, clock and data line next values
    always_comb
    begin
        next_state = state;
        next_transmit_shift_register = transmit_shift_register;
        next_bit_idx = bit_idx;
        next_last_idx = last_idx;
        next_clock_level = clock_level;
        next_data_level = data_level;
        unique case (state)
            smt_pkg::SMT_EMPTY:
            begin
                // idle clock low until a word is in the shifter
                if (!rx_active)
                begin
                    next_clock_level = 1'b0;
                end
                if (load_shifter)
                begin
                    // ninth bit sampled at the moment of the load
                    next_transmit_shift_register = {ninth_transmit_bit, transmit_buffer};
                    next_last_idx = nine_bit_transmit_select ? `SMT_LAST_BIT9
                                                             : `SMT_LAST_BIT8;
                    next_bit_idx = `SMT_RST_IDX;
                    next_state = rx_active ? smt_pkg::SMT_HELD : smt_pkg::SMT_SHIFT;
                end
            end
            smt_pkg::SMT_SHIFT:
            begin
                if (rx_active)
                begin
                    next_state = smt_pkg::SMT_HELD; // paused, not reset
                end
                else if (brg_tick && !clock_level)
                begin
                    // rising edge carries the next bit, lsb first
                    next_clock_level = 1'b1;
                    next_data_level = transmit_shift_register[bit_idx];
                end
                else if (brg_tick)
                begin
                    // falling edge: bit stands across it, then advance
                    next_clock_level = 1'b0;
                    if (bit_idx == last_idx)
                    begin
                        next_state = smt_pkg::SMT_EMPTY; // last bit out
                    end
                    else
                    begin
                        next_bit_idx = bit_idx + `SMT_ONE_IDX;
                    end
                end
            end
            smt_pkg::SMT_HELD:
            begin
                // resume at once when reception ends
                if (!rx_active)
                begin
                    next_state = smt_pkg::SMT_SHIFT;
                    // clock keeps its phase, so no half period is cut short
                end
            end
            default: next_state = smt_pkg::SMT_EMPTY;
        endcase
        // clock runs for the receive path while transmit is held
        if (rx_active && brg_tick)
        begin
            next_clock_level = !clock_level;
        end
        // clearing transmit enable resets the shifter and data line; the buffer keeps its word
        if (!transmit_enable_bit)
        begin
            next_state = smt_pkg::SMT_EMPTY;
            next_bit_idx = `SMT_RST_IDX;
            next_data_level = 1'b0;
            if (!rx_active)
            begin
                next_clock_level = 1'b0;
            end
        end
        // pins: port enable and synchronous mode hand them over; the clock line also needs master select and an enable, the data line transmit enable and no receive
        next_pins.shift_clock_line_out = next_clock_level;
        next_pins.shift_clock_line_oe = port_pin_enable && sync_mode
                                        && clock_source_master_select
                                        && (transmit_enable_bit || rx_active);
        next_pins.serial_data_line_out = next_data_level;
        next_pins.serial_data_line_oe = port_pin_enable && sync_mode
                                        && transmit_enable_bit && !rx_active;
    end

    // shifter and pin flip-flops
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= smt_pkg::SMT_EMPTY;
            transmit_shift_register <= `SMT_RST_SHIFT;
            bit_idx <= `SMT_RST_IDX;
            last_idx <= `SMT_LAST_BIT8;
            clock_level <= 1'b0;
            data_level <= 1'b0;
            o_pins <= '0;
        end
        else
        begin
            state <= next_state;
            transmit_shift_register <= next_transmit_shift_register;
            bit_idx <= next_bit_idx;
            last_idx <= next_last_idx;
            clock_level <= next_clock_level;
            data_level <= next_data_level;
            o_pins <= next_pins;
        end
    end

endmodule // smt_transmitter

`default_nettype wire

/* tb/smt_slave_model.sv */
// behavioural slave receiver clocked by the shift clock line
`timescale 1ns/10ps
`default_nettype none

module smt_slave_model (
    input wire logic i_shift_clock_line,
    input wire logic i_serial_data_line,
    input wire logic i_flush,
    input wire logic i_nine,
    output logic [8:0] o_word,
    output logic [7:0] o_words
);
    logic [8:0] sreg;
    logic [3:0] cnt;

    // takes one bit per falling clock edge, lowest bit first
    always @(negedge i_shift_clock_line or posedge i_flush)
    begin
        if (i_flush)
        begin
            cnt = 4'h0;
            sreg = 9'h000;
            o_words = 8'h00;
        end
        else
        begin
            sreg[cnt] = i_serial_data_line;
            cnt = cnt + 4'h1;
            if (cnt == (i_nine ? 4'h9 : 4'h8))
            begin
                o_word = sreg;
                o_words = o_words + 8'h01;
                cnt = 4'h0;
                sreg = 9'h000;
            end
        end
    end
endmodule // smt_slave_model

`default_nettype wire

/* tb/smt_transmitter_chk.sv */
// assertion checker for the synchronous master transmitter
`timescale 1ns/10ps
`default_nettype none

module smt_transmitter_chk #(
    parameter int HALF_SCALE = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire smt_pkg::smt_bus_req_type i_bus,
    input wire logic i_single_rx_done,
    input wire logic [7:0] o_rdata,
    input wire smt_pkg::smt_pins_type o_pins,
    input wire logic o_tx_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    logic rx_on;
    logic next_rx_on;

    // tracks whether a receive enable is set
    always_comb
    begin
        next_rx_on = rx_on;
        if (i_single_rx_done)
            next_rx_on = 1'b0;
        if (i_bus.wr && i_bus.addr == 3'h1)
            next_rx_on = i_bus.wdata[5] | i_bus.wdata[4];
    end

    // registers the receive enable tracker
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rx_on <= 1'b0;
        else
            rx_on <= next_rx_on;
    end

    chk_rdata_idle: assert property (
        !$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside a read cycle");
    chk_rsvd_zero: assert property (
        i_bus.rd && i_bus.addr[2:1] == 2'b11 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_transmit_enable_bit_abort: assert property (
        i_bus.wr && i_bus.addr == 3'h0 && !i_bus.wdata[5] && !rx_on
        |-> ##2 !o_pins.serial_data_line_oe && !o_pins.shift_clock_line_oe)
        else $error("pins still driven after transmit disable");
    chk_rx_float: assert property (
        i_bus.wr && i_bus.addr == 3'h1 && (i_bus.wdata[5] || i_bus.wdata[4])
        |-> ##2 !o_pins.serial_data_line_oe)
        else $error("data line driven during receive");
    chk_rx_clk_kept: assert property (
        i_bus.wr && i_bus.addr == 3'h1 && i_bus.wdata[7] && (i_bus.wdata[5] || i_bus.wdata[4])
        && o_pins.shift_clock_line_oe |-> ##2 o_pins.shift_clock_line_oe)
        else $error("clock line released during receive");
    chk_data_stable: assert property (
        o_pins.serial_data_line_oe && $past(o_pins.serial_data_line_oe)
        && $fell(o_pins.shift_clock_line_out) |-> $stable(o_pins.serial_data_line_out))
        else $error("data changed at falling clock");
    chk_half_period: assert property (
        o_pins.shift_clock_line_oe && $past(o_pins.shift_clock_line_oe)
        && $changed(o_pins.shift_clock_line_out)
        |=> (!o_pins.shift_clock_line_oe || $stable(o_pins.shift_clock_line_out))[*2])
        else $error("shift clock half period too short");
    chk_irq_off: assert property (
        i_bus.wr && i_bus.addr == 3'h5 && !i_bus.wdata[4] |-> ##2 !o_tx_irq)
        else $error("interrupt not gated off");
endmodule // smt_transmitter_chk

bind smt_transmitter smt_transmitter_chk #(.HALF_SCALE(HALF_SCALE)) smt_transmitter_chk_inst (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_bus(i_bus),
    .i_single_rx_done(i_single_rx_done), .o_rdata(o_rdata), .o_pins(o_pins),
    .o_tx_irq(o_tx_irq));

`default_nettype wire

/* tb/smt_transmitter_tb_top.sv */
// self-checking testbench of the synchronous master transmitter
`timescale 1ns/10ps
`default_nettype none

module smt_transmitter_tb_top;
    logic clk;
    logic nrst;
    smt_pkg::smt_bus_req_type bus;
    logic rx_done;
    logic [7:0] rdata;
    smt_pkg::smt_pins_type pins;
    logic irq;
    logic flush;
    logic nine;
    logic [8:0] word;
    logic [7:0] words;
    logic [7:0] v;
    int error_cnt;
    int n_compared;
    // clock line pulled low, data line pulled high when released
    wire logic clk_line = pins.shift_clock_line_oe ? pins.shift_clock_line_out : 1'b0;
    wire logic data_line = pins.serial_data_line_oe ? pins.serial_data_line_out : 1'b1;

    smt_transmitter #(.HALF_SCALE(1)) smt_transmitter_inst (
        .i_sys_clk(clk), .i_nrst(nrst), .i_bus(bus), .i_single_rx_done(rx_done),
        .o_rdata(rdata), .o_pins(pins), .o_tx_irq(irq));
    smt_slave_model smt_slave_model_inst (
        .i_shift_clock_line(clk_line), .i_serial_data_line(data_line),
        .i_flush(flush), .i_nine(nine), .o_word(word), .o_words(words));

    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 v = rdata;
    endtask

    task automatic flush_model;
        #1 flush = 1'b1;
        #1 flush = 1'b0;
    endtask

    task automatic wait_words(input logic [7:0] n);
        int k;
        k = 0;
        while (words !== n && k < 600)
        begin
            @(posedge clk);
            k++;
        end
        chk("word count", 9'(n), 9'(words));
    endtask

    task automatic t_reset_vals;
        rd(3'h4);
        chk("flag at reset", 9'h010, 9'(v & 8'h10));
        rd(3'h0);
        chk("shifter empty", 9'h002, 9'(v & 8'h02));
        rd(3'h6);
        chk("unmapped read", 9'h000, 9'(v));
        chk("irq at reset", 9'h000, 9'(irq));
    endtask

    task automatic t_setup;
        wr(3'h3, 8'h02);
        wr(3'h1, 8'h80);
        wr(3'h0, 8'h90);
        wr(3'h5, 8'h10);
        wr(3'h0, 8'hB0);
        repeat (3) @(posedge clk);
        #1 chk("clock oe", 9'h001, 9'(pins.shift_clock_line_oe));
        chk("data oe", 9'h001, 9'(pins.serial_data_line_oe));
        chk("irq enabled", 9'h001, 9'(irq));
    endtask

    task automatic t_b2b;
        flush_model;
        wr(3'h2, 8'hA5);
        wr(3'h2, 8'h3C);
        rd(3'h4);
        chk("flag while full", 9'h000, 9'(v & 8'h10));
        chk("irq while full", 9'h000, 9'(irq));
        rd(3'h0);
        chk("shifter busy", 9'h000, 9'(v & 8'h02));
        wait_words(8'h01);
        chk("first word", 9'h0A5, word);
        wait_words(8'h02);
        chk("second word", 9'h03C, word);
        repeat (8) @(posedge clk);
        wr(3'h4, 8'h00);
        rd(3'h4);
        chk("flag kept set", 9'h010, 9'(v & 8'h10));
        rd(3'h0);
        chk("shifter idle", 9'h002, 9'(v & 8'h02));
        wr(3'h5, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("irq masked", 9'h000, 9'(irq));
        wr(3'h5, 8'h10);
    endtask

    task automatic t_nine;
        flush_model;
        nine = 1'b1;
        wr(3'h0, 8'hF1);
        wr(3'h2, 8'h3C);
        wr(3'h0, 8'hF0);
        wait_words(8'h01);
        chk("nine bit word", 9'h13C, word);
        wr(3'h0, 8'hB0);
        nine = 1'b0;
    endtask

    task automatic t_load_first;
        wr(3'h0, 8'h90);
        flush_model;
        wr(3'h2, 8'h5A);
        repeat (60) @(posedge clk);
        chk("no send disabled", 9'h000, 9'(words));
        wr(3'h0, 8'hB0);
        wait_words(8'h01);
        chk("word after enable", 9'h05A, word);
    endtask

    task automatic t_rx_abort;
        flush_model;
        wr(3'h2, 8'hC3);
        repeat (12) @(posedge clk);
        wr(3'h1, 8'h90);
        repeat (2) @(posedge clk);
        #1 chk("data floats", 9'h000, 9'(pins.serial_data_line_oe));
        chk("clock kept", 9'h001, 9'(pins.shift_clock_line_oe));
        wr(3'h1, 8'hA0);
        @(posedge clk);
        rx_done <= 1'b1;
        @(posedge clk);
        rx_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("data driven again", 9'h001, 9'(pins.serial_data_line_oe));
        rd(3'h1);
        chk("single rx cleared", 9'h080, 9'(v & 8'hB0));
        wr(3'h0, 8'h90);
        repeat (2) @(posedge clk);
        #1 v = {6'h00, pins.serial_data_line_oe, pins.shift_clock_line_oe};
        chk("pins float", 9'h000, 9'(v));
        rd(3'h0);
        chk("shifter reset", 9'h002, 9'(v & 8'h02));
    endtask

    // main sequence
    initial
    begin
        bus = '0;
        rx_done = 1'b0;
        nrst = 1'b0;
        flush = 1'b0;
        nine = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset_vals;
        t_setup;
        t_b2b;
        t_nine;
        t_load_first;
        t_rx_abort;
        summarize;
    end

    // watchdog
    initial
    begin
        #(50 * 20000);
        error_cnt++;
        summarize;
    end
endmodule // smt_transmitter_tb_top

`default_nettype wire
